/* File: chan_irq_agg.sv */
// Channel-level interrupt enable, pending and pin logic
`timescale 1ns/100ps
module chan_irq_agg
  import chan_irq_pkg::*;
(
  input  wire logic            sys_clk,    // 40 MHz clock
  input  wire logic            rst,        // Synchronous reset, high
  input  wire host_req_t       host_req,   // Register access strobe, address, data
  input  wire logic [11:0]     src_event,  // Per-channel enabled source event pulse
  output logic      [7:0]      rdata_q,    // Read data, one cycle after rd
  output logic                 int_n_q     // Interrupt pin, active low
);

  logic [11:0] en_q;
  logic [11:0] en_d;
  logic [11:0] pend_q;
  logic [11:0] pend_d;
  logic [11:0] clr_vec;
  logic [11:0] keep_vec;
  logic [11:0] active_vec;
  logic [7:0]  rdata_d;
  logic        wr_en_low;
  logic        wr_en_high;
  logic        sel_en_low;
  logic        sel_en_high;
  logic        sel_pend_low;
  logic        sel_pend_high;
  logic        reg_hit;
  logic        int_n_d;

  // Decode of host writes
  assign wr_en_low  = host_req.wr && (host_req.addr == ADDR_EN_LOW);
  assign wr_en_high = host_req.wr && (host_req.addr == ADDR_EN_HIGH);
  assign en_d[5:0]  = wr_en_low  ? host_req.wdata[5:0] : en_q[5:0];   // [R10]
  assign en_d[11:6] = wr_en_high ? host_req.wdata[5:0] : en_q[11:6];  // [R1]

  // A read of channel n source status at 0xn2 releases its pending bit
  genvar c;
  generate
    for (c = 0; c < NUM_CHAN; c++)
    begin : g_clr
      assign clr_vec[c] = host_req.rd
                          && (host_req.addr == {4'(c), SRC_STAT_LOW_NIBBLE}); // [R8]
    end
  endgenerate

  // New event wins over a clear in the same cycle so no event is lost
  assign keep_vec   = pend_q & ~clr_vec;
  assign pend_d     = keep_vec | src_event;                            // [R7] [R8]
  assign active_vec = pend_q & en_q;                                   // [R2] [R3]

  // Address selects shared by the read mux and the checks below
  assign sel_en_low    = (host_req.addr == ADDR_EN_LOW);
  assign sel_en_high   = (host_req.addr == ADDR_EN_HIGH);
  assign sel_pend_low  = (host_req.addr == ADDR_PEND_LOW);
  assign sel_pend_high = (host_req.addr == ADDR_PEND_HIGH);
  assign reg_hit       = sel_en_low | sel_en_high | sel_pend_low | sel_pend_high;
  assign int_n_d       = ~(|active_vec);                               // [R11]

  // Read mux; unmapped addresses read zero, the 0xn2 status lives elsewhere
  assign rdata_d =
      sel_en_low    ? {RESERVED_BITS, en_q[5:0]}    :
      sel_en_high   ? {RESERVED_BITS, en_q[11:6]}   :
      sel_pend_low  ? {RESERVED_BITS, pend_q[5:0]}  : // [R5]
      sel_pend_high ? {RESERVED_BITS, pend_q[11:6]} : // [R6]
      RDATA_RESET;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      en_q <= EN_RESET;
    end
    else
    begin
      en_q <= en_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pend_q <= PEND_RESET;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  // Read data holds between reads so a slow host may sample late
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdata_q <= RDATA_RESET;
    end
    else
    begin
      rdata_q <= host_req.rd ? rdata_d : rdata_q;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      int_n_q <= INT_N_RESET;
    end
    else
    begin
      int_n_q <= int_n_d;                                              // [R11]
    end
  end

  a_enable_high_write: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    wr_en_high |=> en_q[11:6] == $past(host_req.wdata[5:0]))
    else $error("high master enable not written");

  a_enable_low_write: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    wr_en_low |=> en_q[5:0] == $past(host_req.wdata[5:0]))
    else $error("low master enable not written");

  a_masked_no_int: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    ((pend_q & en_q) == 12'h000) |=> int_n_q)
    else $error("interrupt driven with no enabled pending channel");

  a_enabled_event_int: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    (|(src_event & en_q) && !wr_en_low && !wr_en_high) |-> ##2 !int_n_q)
    else $error("enabled event did not reach the pin");

  a_pend_low_read: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    (host_req.rd && host_req.addr == ADDR_PEND_LOW)
    |=> rdata_q == {2'h0, $past(pend_q[5:0])})
    else $error("low pending read wrong");

  a_pend_high_read: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    (host_req.rd && host_req.addr == ADDR_PEND_HIGH)
    |=> rdata_q == {2'h0, $past(pend_q[11:6])})
    else $error("high pending read wrong");

  a_pend_set: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (|src_event) |=> (pend_q & $past(src_event)) == $past(src_event))
    else $error("event did not set pending bit");

  a_pend_hold: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    (|keep_vec) |=> (pend_q & $past(keep_vec)) == $past(keep_vec))
    else $error("pending bit lost without source status read");

  a_int_follows_pend: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    (|(pend_q & en_q)) |=> !int_n_q)
    else $error("pin inactive while enabled channel pending");

  a_enable_low_read: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    (host_req.rd && sel_en_low) |=> rdata_q == {2'h0, $past(en_q[5:0])})
    else $error("low master enable read wrong");

  a_enable_high_read: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    (host_req.rd && sel_en_high) |=> rdata_q == {2'h0, $past(en_q[11:6])})
    else $error("high master enable read wrong");

  a_unmapped_read: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    (host_req.rd && !reg_hit) |=> rdata_q == 8'h00)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    !host_req.rd |=> rdata_q == $past(rdata_q))
    else $error("read data changed without a read");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    rdata_q[7:6] == 2'h0)
    else $error("reserved read bits not zero");

  a_pend_no_spurious: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    1'b1 |=> (pend_q & ~$past(pend_q) & ~$past(src_event)) == 12'h000)
    else $error("pending bit set without an event");

  a_enable_high_keep: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    !wr_en_high |=> en_q[11:6] == $past(en_q[11:6]))
    else $error("high master enable changed without write");

  a_enable_low_keep: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    !wr_en_low |=> en_q[5:0] == $past(en_q[5:0]))
    else $error("low master enable changed without write");

  // Reset is checked with no disable so the idle state itself is covered
  a_reset_state: assert property (@(posedge sys_clk) // [R7]
    rst |=> (en_q == 12'h000 && pend_q == 12'h000 && int_n_q))
    else $error("state not idle after reset");

  // Per-channel view of release and pin drive
  generate
    for (c = 0; c < NUM_CHAN; c++)
    begin : g_chan_chk
      a_chan_clear: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
        (clr_vec[c] && !src_event[c]) |=> !pend_q[c])
        else $error("pending bit not released by source status read");

      a_chan_drive: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
        (pend_q[c] && en_q[c]) |=> !int_n_q)
        else $error("enabled pending channel left pin inactive");
    end
  endgenerate

endmodule

/* File: chan_irq_pkg.sv */
// Constants and types for the channel interrupt aggregator
// Notes on behaviour
// [R1] Register 0xE0 is read/write and its bits 5..0 hold the master enables of channels 11..6.
// [R2] A channel whose master enable is clear never drives the interrupt pin active.
// [R3] A channel with its master enable set and an enabled source event drives the pin active.
// [R4] Software must also set the source-level enables; the master enable alone raises nothing.
// [R5] Register 0x61 is read-only and its bits 5..0 report the pending state of channels 5..0.
// [R6] Register 0xE1 is read-only and its bits 5..0 report the pending state of channels 11..6.
// [R7] A pending bit reads 0 with nothing awaiting service and 1 with at least one event waiting.
// [R8] A pending bit stays set until the channel's source status register 0xn2 is read.
// [R9] Service software reads the source status register 0xn2 of the flagged channel next.
// [R10] Register 0x60 is read/write and its bits 5..0 hold the master enables of channels 5..0.
// [R11] The interrupt pin is active while any channel is both pending and enabled, else inactive.
package chan_irq_pkg;
  localparam int          NUM_CHAN      = 12;
  localparam int          HALF_CHAN     = 6;
  localparam logic [7:0]  ADDR_EN_LOW   = 8'h60;
  localparam logic [7:0]  ADDR_PEND_LOW = 8'h61;
  localparam logic [7:0]  ADDR_EN_HIGH  = 8'hE0;
  localparam logic [7:0]  ADDR_PEND_HIGH = 8'hE1;
  localparam logic [3:0]  SRC_STAT_LOW_NIBBLE = 4'h2;
  localparam logic [11:0] EN_RESET      = 12'h000;
  localparam logic [11:0] PEND_RESET    = 12'h000;
  localparam logic [7:0]  RDATA_RESET   = 8'h00;
  localparam logic [1:0]  RESERVED_BITS = 2'h0;
  localparam logic        INT_N_RESET   = 1'b1;

  // One host register access, sampled on sys_clk
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;
endpackage

/* File: host_model.sv */
// Host model issuing register accesses
`timescale 1ns/100ps
module host_model import chan_irq_pkg::*; (
  input  wire logic       sys_clk,  // Clock
  input  wire logic [7:0] rdata,    // Read data
  output host_req_t       req = '0  // One strobe per access
);
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge sys_clk) req <= '{w, !w, a, d};
    @(posedge sys_clk) req <= '0;
    #1 q = rdata;
  endtask
endmodule

/* File: tb.sv */
// Self-checking aggregator bench
`timescale 1ns/100ps
module tb import chan_irq_pkg::*; ;
  logic        sys_clk = 0, rst = 1, int_n_q;
  logic [11:0] src_event = '0, en, ev;
  logic [31:0] seed = 32'hA86750F7;
  logic [7:0]  rdata_q, q;
  host_req_t   host_req;
  int          n_mismatch = 0, compares = 0, cyc = 0;
  chan_irq_agg uut (.sys_clk(sys_clk), .rst(rst), .host_req(host_req),
    .src_event(src_event), .rdata_q(rdata_q), .int_n_q(int_n_q));
  host_model host (.sys_clk(sys_clk), .rdata(rdata_q), .req(host_req));
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 5000) stop_test(1);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    return (seed ^= seed << 5);
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    compares++;
    n_mismatch += int'(got !== exp);
    if (got !== exp) $display("Error %0t: got %h want %h", $time, got, exp);
  endtask
  task automatic stop_test(input int late);
    if (n_mismatch + late == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 24; k++)
    begin
      en = k ? 12'(rnd()) : '0;
      ev = k ? seed[27:16] : '1;
      host.acc(1, ADDR_EN_LOW, {seed[13:12], en[5:0]}, q);
      host.acc(1, ADDR_EN_HIGH, {seed[15:14], en[11:6]}, q);
      host.acc(0, ADDR_EN_HIGH, 8'h00, q);
      chk(q, {RESERVED_BITS, en[11:6]});
      host.acc(0, ADDR_EN_LOW, 8'h00, q);
      chk(q, {RESERVED_BITS, en[5:0]});
      @(posedge sys_clk) src_event <= ev;
      @(posedge sys_clk) src_event <= '0;
      host.acc(0, ADDR_PEND_LOW, 8'h00, q);
      chk(q, {RESERVED_BITS, ev[5:0]});
      host.acc(0, ADDR_PEND_HIGH, 8'h00, q);
      chk(q, {RESERVED_BITS, ev[11:6]});
      for (int n = 0; n < 12; n++)
      begin
        @(posedge sys_clk) #1;
        chk({7'h00, int_n_q}, {7'h00, !(|(ev & en))});
        host.acc(0, {n[3:0], SRC_STAT_LOW_NIBBLE}, 8'h00, q);
        chk(q, 8'h00);
        ev[n] = 1'b0;
      end
    end
    stop_test(0);
  end
endmodule
